// [logic/txwb_pkg.sv]
// Package: constants, register map and bus carriers for the transmit status writeback block
package txwb_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_DESC   = 8'h04;
  localparam logic [7:0] OFF_CMD    = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;

  // Field positions
  localparam int CTRL_DISABLE_RETRY_SETTING_BIT   = 0;
  localparam int CTRL_AUI_BIT    = 1;
  localparam int CMD_START_BIT   = 0;
  localparam int ST_RES_BIT      = 13;
  localparam int ST_LATE_COLLISION_FLAG_BIT     = 12;
  localparam int ST_CARRIER_LOST_FLAG_BIT     = 11;
  localparam int ST_RETRY_FAILURE_FLAG_BIT     = 10;
  localparam int ST_FDC_MSB      = 9;
  localparam int ST_BUSY_BIT     = 16;
  localparam int ST_DONE_BIT     = 17;
  localparam int DESC_FIXED_ONE_NIBBLE_MSB   = 15;
  localparam int DESC_FIXED_ONE_NIBBLE_LSB   = 12;
  localparam int DESC_BCNT_MSB   = 11;

  // Reset values
  localparam logic [1:0]  CTRL_RST   = 2'h0;
  localparam logic [15:0] DESC_RST   = 16'hf000;
  localparam logic [15:0] STATUS_RST = 16'h0000;

  // Timing figures and cycle counts (200 MHz system clock)
  localparam int CLK_NS       = 5;
  localparam int FDC_TICK_NS  = 100;
  localparam int BYTE_NS      = 800;
  localparam int SLOT_NS      = 51200;
  localparam int IFG_NS       = 9600;
  localparam int FDC_TICK_CYC = FDC_TICK_NS / CLK_NS;
  localparam int BYTE_CYC     = BYTE_NS / CLK_NS;
  localparam int SLOT_CYC     = (SLOT_NS + CLK_NS - 1) / CLK_NS;
  localparam int IFG_CYC      = (IFG_NS + CLK_NS - 1) / CLK_NS;
  localparam int RETRY_LIMIT  = 16;

  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // AXI4-Lite, master to slave
  typedef struct packed {
    logic       awvalid;
    logic [7:0] awaddr;
    logic       wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic       bready;
    logic       arvalid;
    logic [7:0] araddr;
    logic       rready;
  } axil_m2s_t;

  // AXI4-Lite, slave to master
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_s2m_t;

  // Transmit engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SEND = 3'b010,
    ST_WAIT = 3'b100
  } tx_state_t;

endpackage

// [logic/tx_status_writeback.sv]
// Transmit engine with descriptor byte count and status writeback over AXI4-Lite
// Summary of operation
// - Length is negated byte count; exactly that many bytes sent, count unchanged.
// - Any buffer length accepted, zero bytes included, no minimum size.
// - Reserved status bit 13 always written back as zero.
// - Collision after slot time sets late collision flag, bit 12.
// - No retransmission after a late collision.
// - In AUI mode, carrier lost during own frame sets carrier lost flag.
// - Carrier loss never aborts; whole frame still sent.
// - With disable retry set, first failed attempt sets retry failure flag.
// - 10-bit fault distance counts at 10 MHz from start to collision or carrier loss.
`timescale 1ns/10ps
`default_nettype none
module tx_status_writeback #(
  parameter int SLOT_CYC    = txwb_pkg::SLOT_CYC,
  parameter int RETRY_LIMIT = txwb_pkg::RETRY_LIMIT
) (
  // Clock, reset, enable
  input  wire logic            i_clk_sys,
  input  wire logic            i_sys_rst,
  input  wire logic            i_clk_en,
  // Register bus
  input  wire txwb_pkg::axil_m2s_t i_axil,
  output var  txwb_pkg::axil_s2m_t o_axil,
  // Medium side pins
  input  wire logic            i_collision,
  input  wire logic            i_carrier,
  // Transmit engine
  output logic                 o_tx_active,
  output logic                 o_tx_byte
);

  // Byte-lane merge for register writes
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  logic [1:0]  ctrl_r;
  logic [15:0] desc_r;
  logic [15:0] status_r;
  logic        done_r;
  logic        aw_have_r, w_have_r, bvalid_r, rvalid_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [3:0]  wstrb_r;
  logic [1:0]  bresp_r, rresp_r;
  txwb_pkg::tx_state_t st_r, st_nxt;
  logic        coll_m_r, coll_s_r, car_m_r, car_s_r, car_seen_r;
  logic [11:0] bytes_left_r;
  logic [7:0]  byte_tmr_r;
  logic [15:0] elapsed_r;
  logic [11:0] gap_r;
  logic [4:0]  fdc_tmr_r;
  logic [9:0]  fdc_r;
  logic        fdc_stop_r;
  logic [4:0]  attempts_r;
  logic        byte_stb_r;

  // Synchronisers for medium pins
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      {coll_m_r, coll_s_r, car_m_r, car_s_r} <= 4'h0;
    end else if (i_clk_en) begin
      {coll_m_r, coll_s_r} <= {i_collision, coll_m_r};
      {car_m_r, car_s_r}   <= {i_carrier, car_m_r};
    end
  end

  // Bus decode
  wire        wr_fire  = aw_have_r && w_have_r && !bvalid_r;
  wire        ar_fire  = i_axil.arvalid && !rvalid_r;
  wire        wr_ctrl  = wr_fire && awaddr_r == txwb_pkg::OFF_CTRL;
  wire        wr_desc  = wr_fire && awaddr_r == txwb_pkg::OFF_DESC;
  wire        wr_cmd   = wr_fire && awaddr_r == txwb_pkg::OFF_CMD;
  wire        wr_map   = wr_ctrl || wr_desc || wr_cmd || awaddr_r == txwb_pkg::OFF_STATUS;
  wire        rd_map   = i_axil.araddr inside {txwb_pkg::OFF_CTRL, txwb_pkg::OFF_DESC,
                                               txwb_pkg::OFF_CMD, txwb_pkg::OFF_STATUS};
  wire        disable_retry_setting     = ctrl_r[txwb_pkg::CTRL_DISABLE_RETRY_SETTING_BIT];
  wire        aui      = ctrl_r[txwb_pkg::CTRL_AUI_BIT];
  wire        start    = wr_cmd && wstrb_r[0] && wdata_r[txwb_pkg::CMD_START_BIT]
                         && st_r == txwb_pkg::ST_IDLE;
  wire [11:0] tx_len   = 12'(~desc_r[txwb_pkg::DESC_BCNT_MSB:0] + 12'h001);
  wire [31:0] rd_word  = (i_axil.araddr == txwb_pkg::OFF_CTRL) ? {30'h0, ctrl_r} :
                         (i_axil.araddr == txwb_pkg::OFF_DESC) ? {16'h0, desc_r} :
                         (i_axil.araddr == txwb_pkg::OFF_STATUS) ?
                         {14'h0, done_r, st_r != txwb_pkg::ST_IDLE, status_r} : 32'h0;

  // Handshake outputs; gated by the enable so no handshake completes while the flops are frozen
  // Trade-off: valid drops during a stall rather than letting a response be taken twice
  always_comb begin
    o_axil.awready = i_clk_en && !aw_have_r;
    o_axil.wready  = i_clk_en && !w_have_r;
    o_axil.bvalid  = i_clk_en && bvalid_r;
    o_axil.bresp   = bresp_r;
    o_axil.arready = i_clk_en && !rvalid_r;
    o_axil.rvalid  = i_clk_en && rvalid_r;
    o_axil.rdata   = rdata_r;
    o_axil.rresp   = rresp_r;
  end

  // Write channels: address and data held until both arrive
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      {aw_have_r, w_have_r, bvalid_r} <= 3'h0;
      awaddr_r <= 8'h00;
      wdata_r  <= 32'h0;
      wstrb_r  <= 4'h0;
      bresp_r  <= txwb_pkg::RESP_OKAY;
    end else if (i_clk_en) begin
      if (i_axil.awvalid && !aw_have_r) begin
        aw_have_r <= 1'b1;
        awaddr_r  <= i_axil.awaddr;
      end
      if (i_axil.wvalid && !w_have_r) begin
        w_have_r <= 1'b1;
        wdata_r  <= i_axil.wdata;
        wstrb_r  <= i_axil.wstrb;
      end
      if (wr_fire) begin
        {aw_have_r, w_have_r, bvalid_r} <= 3'b001;
        bresp_r <= wr_map ? txwb_pkg::RESP_OKAY : txwb_pkg::RESP_SLVERR;
      end else if (bvalid_r && i_axil.bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Read channel: one cycle to answer
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0;
      rresp_r  <= txwb_pkg::RESP_OKAY;
    end else if (i_clk_en) begin
      if (ar_fire) begin
        rvalid_r <= 1'b1;
        rdata_r  <= rd_word;
        rresp_r  <= rd_map ? txwb_pkg::RESP_OKAY : txwb_pkg::RESP_SLVERR;
      end else if (rvalid_r && i_axil.rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // Control and descriptor registers; descriptor never rewritten by the engine
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      ctrl_r <= txwb_pkg::CTRL_RST;
      desc_r <= txwb_pkg::DESC_RST;
    end else if (i_clk_en) begin
      if (wr_ctrl) ctrl_r <= 2'(merge16({14'h0, ctrl_r}, wdata_r, wstrb_r));
      // nibble kept as host wrote it
      if (wr_desc && st_r == txwb_pkg::ST_IDLE) desc_r <= merge16(desc_r, wdata_r, wstrb_r);
    end
  end

  // Attempt outcome decode
  wire byte_end  = st_r == txwb_pkg::ST_SEND && byte_tmr_r == 8'(txwb_pkg::BYTE_CYC - 1);
  wire last_byte = byte_end && bytes_left_r == 12'h001;
  wire coll_ev   = st_r == txwb_pkg::ST_SEND && coll_s_r;
  wire late_coll = coll_ev && elapsed_r >= 16'(SLOT_CYC);
  wire early_col = coll_ev && !late_coll;
  wire give_up   = early_col && (disable_retry_setting || attempts_r == 5'(RETRY_LIMIT - 1));
  wire car_loss  = st_r == txwb_pkg::ST_SEND && aui && car_seen_r && !car_s_r;
  wire fdc_tick  = fdc_tmr_r == 5'(txwb_pkg::FDC_TICK_CYC - 1);

  // Next state
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      txwb_pkg::ST_IDLE: begin
        if (start && tx_len != 12'h000) st_nxt = txwb_pkg::ST_SEND;
      end
      txwb_pkg::ST_SEND: begin
        if (late_coll || give_up || (!coll_ev && last_byte)) st_nxt = txwb_pkg::ST_IDLE;
        else if (early_col) st_nxt = txwb_pkg::ST_WAIT;
      end
      txwb_pkg::ST_WAIT: begin
        if (gap_r == 12'h000) st_nxt = txwb_pkg::ST_SEND;
      end
      default: st_nxt = txwb_pkg::ST_IDLE;
    endcase
  end

  // Engine counters
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      st_r         <= txwb_pkg::ST_IDLE;
      bytes_left_r <= 12'h000;
      byte_tmr_r   <= 8'h00;
      elapsed_r    <= 16'h0000;
      gap_r        <= 12'h000;
      attempts_r   <= 5'h00;
      byte_stb_r   <= 1'b0;
      car_seen_r   <= 1'b0;
    end else if (i_clk_en) begin
      st_r       <= st_nxt;
      byte_stb_r <= byte_end && !coll_ev;
      if (start) attempts_r <= 5'h00;
      else if (early_col) attempts_r <= attempts_r + 5'h01;
      if (st_r != txwb_pkg::ST_SEND) begin
        bytes_left_r <= tx_len;
        byte_tmr_r   <= 8'h00;
        elapsed_r    <= 16'h0000;
        car_seen_r   <= 1'b0;
      end else begin
        byte_tmr_r <= byte_end ? 8'h00 : byte_tmr_r + 8'h01;
        if (byte_end) bytes_left_r <= bytes_left_r - 12'h001;
        if (elapsed_r != 16'hffff) elapsed_r <= elapsed_r + 16'h0001;
        if (car_s_r) car_seen_r <= 1'b1;
      end
      gap_r <= (st_r == txwb_pkg::ST_WAIT) ? gap_r - 12'h001 : 12'(txwb_pkg::IFG_CYC - 1);
    end
  end

  // Fault distance counter at 10 MHz; restarts with each attempt
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      fdc_tmr_r  <= 5'h00;
      fdc_r      <= 10'h000;
      fdc_stop_r <= 1'b0;
    end else if (i_clk_en) begin
      if (start || st_r == txwb_pkg::ST_WAIT) begin
        fdc_tmr_r  <= 5'h00;
        fdc_r      <= 10'h000;
        fdc_stop_r <= 1'b0;
      end else if (st_r == txwb_pkg::ST_SEND) begin
        fdc_tmr_r <= fdc_tick ? 5'h00 : fdc_tmr_r + 5'h01;
        if (coll_ev || car_loss) fdc_stop_r <= 1'b1;
        else if (fdc_tick && !fdc_stop_r) fdc_r <= fdc_r + 10'h001;
      end
    end
  end

  // Status writeback at end of frame; flags cleared by next start
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      status_r <= txwb_pkg::STATUS_RST;
      done_r   <= 1'b0;
    end else if (i_clk_en) begin
      if (start) begin
        status_r <= txwb_pkg::STATUS_RST;
        done_r   <= tx_len == 12'h000;
      end else begin
        status_r[txwb_pkg::ST_RES_BIT] <= 1'b0;
        if (late_coll) status_r[txwb_pkg::ST_LATE_COLLISION_FLAG_BIT] <= 1'b1;
        if (car_loss) status_r[txwb_pkg::ST_CARRIER_LOST_FLAG_BIT] <= 1'b1;
        if (give_up) status_r[txwb_pkg::ST_RETRY_FAILURE_FLAG_BIT] <= 1'b1;
        if (st_r == txwb_pkg::ST_SEND && st_nxt == txwb_pkg::ST_IDLE) begin
          done_r <= 1'b1;
          status_r[txwb_pkg::ST_FDC_MSB:0] <= fdc_r;
        end
      end
    end
  end

  assign o_tx_active = st_r == txwb_pkg::ST_SEND;
  assign o_tx_byte   = byte_stb_r;

  // Helper: bytes sent in the current attempt
  logic [11:0] sent_r;
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) sent_r <= 12'h000;
    else if (i_clk_en) sent_r <= (st_r != txwb_pkg::ST_SEND) ? 12'h000 : sent_r + 12'(byte_end);
  end

  sequence s_early_coll_disable_retry_setting;
    early_col && disable_retry_setting;
  endsequence
  sequence s_early_coll_retry;
    early_col && !disable_retry_setting && attempts_r < 5'(RETRY_LIMIT - 1);
  endsequence

  AST_LEN_EXACT: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst || !i_clk_en)
    last_byte && !coll_ev |-> sent_r + 12'h001 == tx_len)
    else $error("byte count differs from negated descriptor count");
  AST_ZERO_LEN: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst || !i_clk_en)
    start && tx_len == 12'h000 |=> done_r && st_r == txwb_pkg::ST_IDLE)
    else $error("zero length buffer not completed");
  AST_RES_ZERO: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst || !i_clk_en)
    ar_fire && i_axil.araddr == txwb_pkg::OFF_STATUS |=> !o_axil.rdata[txwb_pkg::ST_RES_BIT])
    else $error("reserved status bit not zero");
  AST_LATE_FLAG: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst || !i_clk_en)
    coll_ev && elapsed_r >= 16'(SLOT_CYC) |=> status_r[txwb_pkg::ST_LATE_COLLISION_FLAG_BIT] && done_r)
    else $error("late collision flag missing");
  AST_LATE_NO_RETRY: assert property (@(posedge i_clk_sys)
    disable iff (i_sys_rst || !i_clk_en) late_coll |=> st_r == txwb_pkg::ST_IDLE [*2])
    else $error("retry after late collision");
  AST_CAR_FLAG: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst || !i_clk_en)
    car_loss |=> status_r[txwb_pkg::ST_CARRIER_LOST_FLAG_BIT])
    else $error("carrier lost flag missing");
  AST_CAR_NO_ABORT: assert property (@(posedge i_clk_sys)
    disable iff (i_sys_rst || !i_clk_en) car_loss && !coll_ev && !last_byte |=> o_tx_active)
    else $error("carrier loss aborted frame");
  AST_DISABLE_RETRY_SETTING_FAIL: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst || !i_clk_en)
    s_early_coll_disable_retry_setting |=> status_r[txwb_pkg::ST_RETRY_FAILURE_FLAG_BIT] && st_r == txwb_pkg::ST_IDLE)
    else $error("retry failure not set with retries disabled");
  AST_FDC_COUNT: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst || !i_clk_en)
    o_tx_active && fdc_tick && !fdc_stop_r && !coll_ev && !car_loss
    |=> fdc_r == $past(fdc_r) + 10'h001)
    else $error("fault distance counter did not advance");
  AST_RETRY_GAP: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst || !i_clk_en)
    s_early_coll_retry |=> st_r == txwb_pkg::ST_WAIT && !status_r[txwb_pkg::ST_RETRY_FAILURE_FLAG_BIT])
    else $error("retry failure before retry limit");

endmodule
`default_nettype wire

// [verification/medium_model.sv]
// Medium model: collision and carrier seen by the transmit engine
`timescale 1ns/10ps
`default_nettype none
module medium_model (
  // Clock and engine state
  input  wire logic        i_clk_sys,
  input  wire logic        i_tx_active,
  // Scenario knobs, cycles into an attempt, zero means never
  input  wire logic [15:0] i_coll_at,
  input  wire logic [15:0] i_drop_at,
  // Medium pins
  output logic             o_collision,
  output logic             o_carrier
);
  logic [15:0] cnt;
  // Attempt age, restarted for every retry
  always @(posedge i_clk_sys) begin
    cnt <= i_tx_active ? cnt + 16'h1 : 16'h0;
  end
  // Collision recurs on each attempt so retries meet it again
  assign o_collision = i_tx_active && i_coll_at != 16'h0 && cnt >= i_coll_at;
  // Carrier only during own frames; a quiet medium reads low
  assign o_carrier   = i_tx_active && (i_drop_at == 16'h0 || cnt < i_drop_at);
endmodule
`default_nettype wire

// [verification/test_tx_status_writeback.sv]
// Testbench for the transmit status writeback block
`timescale 1ns/10ps
`default_nettype none
module test_tx_status_writeback;
  typedef struct {
    logic [31:0] ctrl, desc;
    logic [15:0] coll, drop;
    logic [3:0]  flags;
    int          bytes, tries;
  } row_t;
  logic                clk = 0;
  logic                rst = 1;
  logic                en = 1'b1;
  logic                coll, carr, act, byte_p, prev;
  logic [15:0]         coll_at = 16'h0;
  logic [15:0]         drop_at = 16'h0;
  logic [31:0]         d;
  logic [1:0]          r;
  txwb_pkg::axil_m2s_t m = '0;
  txwb_pkg::axil_s2m_t s;
  int                  errors = 0;
  int                  n_compared = 0;
  int                  nbytes = 0;
  int                  tries = 0;
  // Fixed_one_nibble nibble and negated count always supplied by the host
  row_t rows [7] = '{
    '{32'h0, 32'hfffd, 16'd0,   16'd0,   4'h0, 3, 1},
    '{32'h0, 32'hf000, 16'd0,   16'd0,   4'h0, 0, 0},
    '{32'h0, 32'hfffb, 16'd600, 16'd0,   4'h4, 3, 1},
    '{32'h1, 32'hfffb, 16'd100, 16'd0,   4'h1, 0, 1},
    '{32'h0, 32'hfffb, 16'd100, 16'd0,   4'h1, 0, 16},
    '{32'h2, 32'hfffc, 16'd0,   16'd200, 4'h2, 4, 1},
    '{32'h0, 32'hfffc, 16'd0,   16'd200, 4'h0, 4, 1}
  };

  // Clock, 200 MHz
  always #2.5 clk = ~clk;

  tx_status_writeback #(.SLOT_CYC(400), .RETRY_LIMIT(txwb_pkg::RETRY_LIMIT)) u_dut (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_clk_en(en), .i_axil(m), .o_axil(s),
    .i_collision(coll), .i_carrier(carr), .o_tx_active(act), .o_tx_byte(byte_p));
  medium_model u_med (.i_clk_sys(clk), .i_tx_active(act), .i_coll_at(coll_at),
    .i_drop_at(drop_at), .o_collision(coll), .o_carrier(carr));

  // Byte pulses and attempt starts, counted per frame
  always @(posedge clk) begin
    // A pulse lasts one enabled cycle; stalled edges do not count it again
    if (byte_p === 1'b1 && en === 1'b1) nbytes++;
    if (act === 1'b1 && prev !== 1'b1) tries++;
    prev <= act;
  end

  task automatic test_done;
    $display("Compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic hang;
    errors++;
    $display("ERROR t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
    test_done;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Write; idle edge first so ready levels never change twice in a step
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int k;
    @(posedge clk);
    m.awaddr <= a;
    m.wdata <= v;
    m.wstrb <= 4'hf;
    m.awvalid <= 1'b1;
    m.wvalid <= 1'b1;
    m.bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (m.awvalid && s.awready) m.awvalid <= 1'b0;
      if (m.wvalid && s.wready) m.wvalid <= 1'b0;
      if (s.bvalid === 1'b1) break;
    end
    r = s.bresp;
    m.bready <= 1'b0;
    if (k == 50) hang;
  endtask

  task automatic rd(input logic [7:0] a);
    int k;
    @(posedge clk);
    m.araddr <= a;
    m.arvalid <= 1'b1;
    m.rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (m.arvalid && s.arready) m.arvalid <= 1'b0;
      if (s.rvalid === 1'b1) break;
    end
    d = s.rdata;
    r = s.rresp;
    m.rready <= 1'b0;
    if (k == 50) hang;
  endtask

  // Poll status until done, bounded
  task automatic wait_done;
    int k;
    for (k = 0; k < 20000; k++) begin
      rd(txwb_pkg::OFF_STATUS);
      if (d[txwb_pkg::ST_DONE_BIT] === 1'b1) break;
    end
    if (k == 20000) hang;
  endtask

  task automatic launch(input logic [31:0] ctrl, input logic [31:0] desc);
    wr(txwb_pkg::OFF_CTRL, ctrl);
    wr(txwb_pkg::OFF_DESC, desc);
    nbytes = 0;
    tries = 0;
    wr(txwb_pkg::OFF_CMD, 32'h1);
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(txwb_pkg::OFF_CTRL);
    chk(d, {30'h0, txwb_pkg::CTRL_RST});
    rd(txwb_pkg::OFF_DESC);
    chk(d, {16'h0, txwb_pkg::DESC_RST});
    rd(txwb_pkg::OFF_STATUS);
    chk(d, {16'h0, txwb_pkg::STATUS_RST});
    rd(8'h10);
    chk(d, 32'h0);
    chk(r, txwb_pkg::RESP_SLVERR);
    wr(8'h10, 32'h1);
    chk(r, txwb_pkg::RESP_SLVERR);
    foreach (rows[i]) begin
      coll_at <= rows[i].coll;
      drop_at <= rows[i].drop;
      launch(rows[i].ctrl, rows[i].desc);
      wait_done;
      chk(d[15:10], {2'b00, rows[i].flags});
      chk(nbytes, rows[i].bytes);
      chk(tries, rows[i].tries);
      // distance trusted only with retry failure
      if (rows[i].flags[0]) begin
        chk(d[9:0] + 10'd1 - 10'(rows[i].coll / 20) <= 10'd2, 1'b1);
      end
      rd(txwb_pkg::OFF_DESC);
      chk(d, rows[i].desc);
    end
    // Descriptor write and second start while busy are both ignored
    coll_at <= 16'h0;
    drop_at <= 16'h0;
    launch(32'h0, 32'hfffb);
    wr(txwb_pkg::OFF_DESC, 32'hfffe);
    wr(txwb_pkg::OFF_CMD, 32'h1);
    chk(r, txwb_pkg::RESP_OKAY);
    rd(txwb_pkg::OFF_STATUS);
    chk(d[txwb_pkg::ST_BUSY_BIT], 1'b1);
    wait_done;
    chk(nbytes, 5);
    chk(tries, 1);
    rd(txwb_pkg::OFF_DESC);
    chk(d, 32'hfffb);
    // Enable low freezes a frame longer than the frame itself; nothing is lost
    launch(32'h0, 32'hfffb);
    repeat (100) @(posedge clk);
    en <= 1'b0;
    repeat (1000) @(posedge clk);
    chk(act, 1'b1);
    en <= 1'b1;
    wait_done;
    chk(nbytes, 5);
    chk(tries, 1);
    // Reset in mid-frame clears engine and registers
    launch(32'h0, 32'hfffb);
    repeat (100) @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(act, 1'b0);
    rd(txwb_pkg::OFF_STATUS);
    chk(d, 32'h0);
    rd(txwb_pkg::OFF_DESC);
    chk(d, {16'h0, txwb_pkg::DESC_RST});
    test_done;
  end
endmodule
`default_nettype wire
